// *** hw/bfi_params.svh ***
`ifndef BFI_PARAMS_SVH
`define BFI_PARAMS_SVH
`define BFI_CLK_MHZ 100
`define BFI_TICK_MS 50
`define BFI_PROBE_MS 100
`define BFI_OFF_CTRL 8'h00
`define BFI_OFF_STAT 8'h04
`define BFI_OFF_CHAN 8'h08
`define BFI_CTRL_RST 16'h0800
`define BFI_ALIAS_LSB 0
`define BFI_BAUD_LSB 8
`define BFI_REQ_BIT 10
`define BFI_PDO_BIT 11
`define BFI_RS485_ADDR 8'h01
`define BFI_MCT_0 16'h0064
`define BFI_MCT_1 16'h0032
`define BFI_MCT_2 16'h0019
`define BFI_MCT_3 16'h000d
`define BFI_CHAN_COUNTS 16'h1111
`define BFI_PHASE_LAST 5'h13
`define BFI_FLASH_ON 5'h04
`define BFI_DBL_START 5'h08
`define BFI_DBL_END 5'h0c
`define BFI_HALF_2HZ 5'h05
`endif

// *** hw/bfi_pkg.sv ***
package bfi_pkg;
  typedef enum logic [1:0] {ST_PROBE = 2'h0, ST_CFG = 2'h1, ST_DONE = 2'h3} bfi_probe_t;
  typedef enum logic [1:0] {ESM_INIT = 2'h0, ESM_PREOP = 2'h1, ESM_SAFEOP = 2'h2, ESM_OP = 2'h3} bfi_esm_t;
  typedef enum logic [1:0] {ERR_NONE = 2'h0, ERR_LOCAL = 2'h1, ERR_WDOG = 2'h2, ERR_CONFIG = 2'h3} bfi_err_t;
  typedef logic [1:0] bfi_baud_t;
endpackage : bfi_pkg

// *** hw/bfi_status_led.sv ***
// Notes on behaviour
// - Port indicator: dark without link, lit with link, 10 Hz flicker with traffic.
// - Nonzero rotary switch value is the alias, zero selects the saved alias.
// - During the presence test the RS485 indicator alternates red and green at 5 Hz.
// - Required drive with failed communication shows steady red.
// - Communication fine but drive error shows steady red and green.
// - Non-required drive without drive error flashes green at 2 Hz.
// - Non-required drive with drive error flashes red and green together at 2 Hz.
// - Communication fine and no drive error shows steady green.
// - Presence test runs after power-up; a found drive gets the saved baud rate.
// - The presence test sets the message-complete time matching the chosen baud rate.
// - The presence test sets the drive link address to one.
// - Test end shows steady red when no drive, steady green when found.
// - Run indicator: dark INIT, 2.5 Hz PREOP, 1 Hz single SAFEOP, lit OP.
// - Error indicator: dark, 1 Hz single, 1 Hz double, or 2.5 Hz by fault.
// - One send and receive service channel, one process channel pair, process active.
`timescale 1ns/1ps
`default_nettype none
`include "bfi_params.svh"
module bfi_status_led #(
  parameter int TICK_CYCLES = `BFI_TICK_MS * 1000 * `BFI_CLK_MHZ,
  parameter int PROBE_CYCLES = `BFI_PROBE_MS * 1000 * `BFI_CLK_MHZ
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [1:0] link_up_in,
  input wire logic [1:0] activity_in,
  input wire logic [7:0] alias_switch_in,
  input wire bfi_pkg::bfi_esm_t esm_state_in,
  input wire bfi_pkg::bfi_err_t err_code_in,
  input wire logic drive_answer_in,
  input wire logic comm_err_in,
  input wire logic drive_err_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic [1:0] port_led_out,
  output logic rs_red_out,
  output logic rs_green_out,
  output logic run_led_out,
  output logic err_led_out,
  output logic [7:0] alias_out,
  output logic probe_req_out,
  output logic cfg_strobe_out,
  output bfi_pkg::bfi_baud_t cfg_baud_out,
  output logic [15:0] cfg_mct_out,
  output logic [7:0] cfg_addr_out,
  output logic pdo_active_out
);
  import bfi_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [11:0] sync1_reg;
  logic [11:0] sync2_reg;
  wire logic [1:0] link_s = sync2_reg[1:0];
  wire logic [1:0] act_s = sync2_reg[3:2];
  wire logic [7:0] alias_s = sync2_reg[11:4];

  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      sync1_reg <= 12'h000;
      sync2_reg <= 12'h000;
    end
    else
    begin
      sync1_reg <= {alias_switch_in, activity_in, link_up_in};
      sync2_reg <= sync1_reg;
    end

  // ----------------------------------------------------------------
  // Blink prescaler
  // ----------------------------------------------------------------
  // One 50 ms tick feeds every pattern, so all indicators stay in step.
  logic [$clog2(TICK_CYCLES)-1:0] pre_reg;
  logic [2:0] fast_reg;
  logic [4:0] phase_reg;
  wire logic tick = (pre_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
  wire logic blink_10hz = fast_reg[0];
  wire logic blink_5hz = fast_reg[1];
  wire logic blink_2p5hz = fast_reg[2];
  wire logic blink_2hz = (phase_reg < `BFI_HALF_2HZ) ||
    ((phase_reg >= 5'(2 * `BFI_HALF_2HZ)) && (phase_reg < 5'(3 * `BFI_HALF_2HZ)));
  wire logic single_1hz = phase_reg < `BFI_FLASH_ON;
  wire logic double_1hz = single_1hz || (phase_reg >= `BFI_DBL_START && phase_reg < `BFI_DBL_END);

  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      pre_reg <= '0;
      fast_reg <= 3'h0;
      phase_reg <= 5'h00;
    end
    else
    begin
      pre_reg <= tick ? '0 : pre_reg + 1'b1;
      fast_reg <= tick ? fast_reg + 3'h1 : fast_reg;
      phase_reg <= !tick ? phase_reg : (phase_reg == `BFI_PHASE_LAST) ? 5'h00 : phase_reg + 5'h01;
    end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] ctrl_reg;
  wire logic [7:0] saved_alias = ctrl_reg[`BFI_ALIAS_LSB +: 8];
  wire bfi_baud_t saved_baud = ctrl_reg[`BFI_BAUD_LSB +: 2];
  wire logic required = ctrl_reg[`BFI_REQ_BIT];
  wire logic sel_ctrl = (addr_in == `BFI_OFF_CTRL);
  wire logic sel_stat = (addr_in == `BFI_OFF_STAT);
  wire logic sel_chan = (addr_in == `BFI_OFF_CHAN);
  bfi_probe_t state_reg;
  bfi_probe_t state_next;
  logic found_reg;
  wire logic [15:0] stat_word = {alias_out, 2'h0, rs_green_out, rs_red_out, found_reg, state_reg, state_reg != ST_DONE};
  wire logic [15:0] rdata_next = sel_ctrl ? ctrl_reg : sel_stat ? stat_word : sel_chan ? `BFI_CHAN_COUNTS : 16'h0000;

  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      ctrl_reg <= `BFI_CTRL_RST;
      rdata_out <= 16'h0000;
    end
    else
    begin
      if (wr_in && sel_ctrl)
        ctrl_reg <= wdata_in;
      rdata_out <= rd_in ? rdata_next : 16'h0000;
    end

  // ----------------------------------------------------------------
  // Presence test
  // ----------------------------------------------------------------
  function automatic logic [15:0] mct_of(input bfi_baud_t b);
    unique case (b)
      2'h0: mct_of = `BFI_MCT_0;
      2'h1: mct_of = `BFI_MCT_1;
      2'h2: mct_of = `BFI_MCT_2;
      2'h3: mct_of = `BFI_MCT_3;
    endcase
  endfunction : mct_of

  logic [$clog2(PROBE_CYCLES)-1:0] wait_reg;
  wire logic probe_timeout = (wait_reg == ($clog2(PROBE_CYCLES))'(PROBE_CYCLES - 1));

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_PROBE: if (drive_answer_in) state_next = ST_CFG; else if (probe_timeout) state_next = ST_DONE;
      ST_CFG: state_next = ST_DONE;
      ST_DONE: state_next = ST_DONE;
      default: state_next = ST_PROBE;
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      state_reg <= ST_PROBE;
      wait_reg <= '0;
      found_reg <= 1'b0;
      probe_req_out <= 1'b0;
      cfg_strobe_out <= 1'b0;
      cfg_baud_out <= 2'h0;
      cfg_mct_out <= 16'h0000;
      cfg_addr_out <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg <= (state_reg == ST_PROBE) ? wait_reg + 1'b1 : '0;
      probe_req_out <= (state_next == ST_PROBE);
      cfg_strobe_out <= (state_reg == ST_CFG);
      if (state_reg == ST_CFG)
      begin
        found_reg <= 1'b1;
        cfg_baud_out <= saved_baud;
        cfg_mct_out <= mct_of(saved_baud);
        cfg_addr_out <= `BFI_RS485_ADDR;
      end
    end

  // ----------------------------------------------------------------
  // RS485 indicator
  // ----------------------------------------------------------------
  // A found result stays up until the drive status first moves; a no-drive result stays red for good.
  logic comm_d_reg;
  logic drv_d_reg;
  logic eval_reg;
  wire logic status_moved = (comm_err_in != comm_d_reg) || (drive_err_in != drv_d_reg);
  wire logic in_test = (state_reg != ST_DONE);
  logic rs_red_next;
  logic rs_green_next;

  always_comb
  begin
    rs_red_next = 1'b0;
    rs_green_next = 1'b0;
    if (in_test)
    begin
      rs_red_next = blink_5hz;
      rs_green_next = !blink_5hz;
    end
    else if (!found_reg || !eval_reg)
    begin
      rs_red_next = !found_reg;
      rs_green_next = found_reg;
    end
    else if (required && comm_err_in)
      rs_red_next = 1'b1;
    else if (required)
    begin
      rs_red_next = drive_err_in;
      rs_green_next = 1'b1;
    end
    else if (!comm_err_in)
    begin
      rs_red_next = drive_err_in && blink_2hz;
      rs_green_next = blink_2hz;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      comm_d_reg <= 1'b0;
      drv_d_reg <= 1'b0;
      eval_reg <= 1'b0;
      rs_red_out <= 1'b0;
      rs_green_out <= 1'b0;
    end
    else
    begin
      comm_d_reg <= comm_err_in;
      drv_d_reg <= drive_err_in;
      eval_reg <= eval_reg || (!in_test && status_moved);
      rs_red_out <= rs_red_next;
      rs_green_out <= rs_green_next;
    end

  // ----------------------------------------------------------------
  // Port, run, error and alias indicators
  // ----------------------------------------------------------------
  logic [1:0] act_hold_reg;
  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      // Traffic is held until the flicker next ends a lit half, so a burst in a dark half stays visible.
      wire logic led_next = link_s[p] && (!act_hold_reg[p] || blink_10hz);
      always_ff @(posedge clock_in or negedge reset_n_in)
        if (!reset_n_in)
        begin
          act_hold_reg[p] <= 1'b0;
          port_led_out[p] <= 1'b0;
        end
        else
        begin
          act_hold_reg[p] <= act_s[p] || (act_hold_reg[p] && !(tick && blink_10hz));
          port_led_out[p] <= led_next;
        end
    end
  endgenerate

  logic run_next;
  logic err_next;
  always_comb
  begin
    unique case (esm_state_in)
      ESM_INIT: run_next = 1'b0;
      ESM_PREOP: run_next = blink_2p5hz;
      ESM_SAFEOP: run_next = single_1hz;
      ESM_OP: run_next = 1'b1;
    endcase
    unique case (err_code_in)
      ERR_NONE: err_next = 1'b0;
      ERR_LOCAL: err_next = single_1hz;
      ERR_WDOG: err_next = double_1hz;
      ERR_CONFIG: err_next = blink_2p5hz;
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      run_led_out <= 1'b0;
      err_led_out <= 1'b0;
      alias_out <= 8'h00;
      pdo_active_out <= 1'b0;
    end
    else
    begin
      run_led_out <= run_next;
      err_led_out <= err_next;
      alias_out <= (alias_s != 8'h00) ? alias_s : saved_alias;
      pdo_active_out <= ctrl_reg[`BFI_PDO_BIT];
    end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_answered;
    state_reg == ST_PROBE && drive_answer_in;
  endsequence
  sequence s_configured;
    cfg_strobe_out ##1 (state_reg == ST_DONE && found_reg);
  endsequence

  a_cfg_after_answer: assert property (s_answered |-> ##2 s_configured)
    else $error("drive answer not followed by configuration");
  a_cfg_mct_match: assert property (cfg_strobe_out |-> cfg_mct_out == mct_of(cfg_baud_out))
    else $error("message complete time does not match baud");
  a_cfg_addr_one: assert property (cfg_strobe_out |-> cfg_addr_out == `BFI_RS485_ADDR)
    else $error("drive address not one");
  a_test_alternates: assert property ($past(in_test) && $past(reset_n_in) |-> rs_red_out != rs_green_out)
    else $error("rs485 indicator not alternating during test");
  a_not_found_red: assert property (state_reg == ST_DONE && !found_reg |=> rs_red_out && !rs_green_out)
    else $error("missing drive not shown red");
  a_port_dark: assert property (!link_s[0] |=> !port_led_out[0])
    else $error("port indicator lit without link");
  a_alias_select: assert property (alias_s != 8'h00 |=> alias_out == $past(alias_s))
    else $error("switch alias not taken");
  a_run_oper: assert property (esm_state_in == ESM_OP |=> run_led_out)
    else $error("run indicator dark in operational");
  a_err_none: assert property (err_code_in == ERR_NONE |=> !err_led_out)
    else $error("error indicator lit without error");
endmodule : bfi_status_led
`default_nettype wire

// *** tb/bfi_drive_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Drive electronics behind the RS485 link
// ----------------------------------------
module bfi_drive_model (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic probe_req_in,
  input wire logic present_in,
  input wire logic [7:0] delay_in,
  output logic answer_out
);
  logic [7:0] wait_reg;
  // An absent drive stays silent, so the probe must end by its own timeout.
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wait_reg <= 8'h00;
      answer_out <= 1'b0;
    end
    else
    begin
      wait_reg <= probe_req_in ? wait_reg + 8'h01 : 8'h00;
      answer_out <= present_in && probe_req_in && (wait_reg >= delay_in);
    end
  end
endmodule : bfi_drive_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bfi_pkg::*;
  logic clock_in = 0, reset_n_in = 0, drive_answer_in, comm_err_in = 0, drive_err_in = 0, wr_in = 0, rd_in = 0;
  logic present = 1, seen, probe_req_out, cfg_strobe_out, rs_red_out, rs_green_out, run_led_out, err_led_out;
  logic pdo_active_out;
  logic [1:0] link_up_in = 0, activity_in = 0, port_led_out;
  logic [7:0] alias_switch_in = 0, addr_in = 0, alias_out, cfg_addr_out, dly = 8'h08;
  logic [15:0] wdata_in = 0, rdata_out, cfg_mct_out, d;
  bfi_esm_t esm_state_in = ESM_INIT;
  bfi_err_t err_code_in = ERR_NONE;
  bfi_baud_t cfg_baud_out;
  int errors = 0, checks_done = 0, cycles = 0, cnt [7];
  // ----------------------------------------
  // Clock, partner and device
  // ----------------------------------------
  initial forever #5 clock_in = ~clock_in;
  bfi_drive_model u_drive (.clock_in(clock_in), .reset_n_in(reset_n_in), .probe_req_in(probe_req_out),
    .present_in(present), .delay_in(dly), .answer_out(drive_answer_in));
  bfi_status_led #(.TICK_CYCLES(8), .PROBE_CYCLES(20)) u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .link_up_in(link_up_in), .activity_in(activity_in), .alias_switch_in(alias_switch_in),
    .esm_state_in(esm_state_in), .err_code_in(err_code_in), .drive_answer_in(drive_answer_in),
    .comm_err_in(comm_err_in), .drive_err_in(drive_err_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .port_led_out(port_led_out), .rs_red_out(rs_red_out),
    .rs_green_out(rs_green_out), .run_led_out(run_led_out), .err_led_out(err_led_out), .alias_out(alias_out),
    .probe_req_out(probe_req_out), .cfg_strobe_out(cfg_strobe_out), .cfg_baud_out(cfg_baud_out),
    .cfg_mct_out(cfg_mct_out), .cfg_addr_out(cfg_addr_out), .pdo_active_out(pdo_active_out));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    v = rdata_out;
    @(posedge clock_in);
  endtask : rd
  task automatic do_reset(input logic p);
    @(posedge clock_in);
    present <= p;
    reset_n_in <= 1'b0;
    comm_err_in <= 1'b0;
    drive_err_in <= 1'b0;
    repeat (16) @(posedge clock_in);
    chk("leds_in_reset", 16'h0000, {port_led_out, rs_red_out, rs_green_out, run_led_out, err_led_out});
    reset_n_in <= 1'b1;
  endtask : do_reset
  // Counts lit cycles over 320 cycles, whole periods of every pattern, so the phase does not matter.
  task automatic meas;
    repeat (8) @(posedge clock_in);
    for (int i = 0; i < 7; i++) cnt[i] = 0;
    repeat (320)
    begin
      @(negedge clock_in);
      cnt[0] += rs_red_out;
      cnt[1] += rs_green_out;
      cnt[2] += run_led_out;
      cnt[3] += err_led_out;
      cnt[4] += port_led_out[0];
      cnt[5] += port_led_out[1];
      cnt[6] += rs_red_out & rs_green_out;
    end
    @(posedge clock_in);
  endtask : meas
  task automatic wait_strobe;
    seen = 1'b0;
    for (int k = 0; k < 40 && !seen; k++)
    begin
      @(negedge clock_in);
      seen = cfg_strobe_out;
    end
  endtask : wait_strobe
  task automatic done(input string n);
    $display("test %s finished, mismatches so far %0d", n, errors);
  endtask : done
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_probe(input int b);
    logic [15:0] mct [4] = '{16'h0064, 16'h0032, 16'h0019, 16'h000d};
    dly <= 8'(8 + 2 * b);
    do_reset(1'b1);
    wr(8'h00, 16'h0800 | 16'(b << 8));
    @(negedge clock_in);
    chk("probe_alternate", 16'h0001, 16'(rs_red_out ^ rs_green_out));
    wait_strobe();
    chk("cfg_seen", 16'h0001, 16'(seen));
    chk("cfg_baud", 16'(b), 16'(cfg_baud_out));
    chk("cfg_mct", mct[b], cfg_mct_out);
    chk("cfg_addr", 16'h0001, 16'(cfg_addr_out));
    repeat (4) @(posedge clock_in);
    chk("found_leds", 16'h0001, {rs_red_out, rs_green_out});
    done("probe");
  endtask : t_probe
  task automatic t_absent;
    do_reset(1'b0);
    wait_strobe();
    chk("no_cfg", 16'h0000, 16'(seen));
    chk("absent_leds", 16'h0002, {rs_red_out, rs_green_out});
    chk("probe_end", 16'h0000, 16'(probe_req_out));
    rd(8'h04, d);
    chk("stat_absent", 16'h0016, d);
    done("absent");
  endtask : t_absent
  task automatic t_status;
    dly <= 8'h02;
    do_reset(1'b1);
    wr(8'h00, 16'h0c00);
    wait_strobe();
    @(posedge clock_in);
    comm_err_in <= 1'b1;
    meas();
    chk("req_comm_err", 16'(320), 16'(cnt[0] + cnt[1] * 2));
    comm_err_in <= 1'b0;
    drive_err_in <= 1'b1;
    meas();
    chk("drive_err", 16'(320), 16'(cnt[6]));
    wr(8'h00, 16'h0800);
    drive_err_in <= 1'b0;
    meas();
    chk("free_green", 16'(160), 16'(cnt[1] + cnt[0] * 2));
    drive_err_in <= 1'b1;
    meas();
    chk("free_both", 16'(480), 16'(cnt[6] + cnt[0] + cnt[1]));
    wr(8'h00, 16'h0c00);
    drive_err_in <= 1'b0;
    meas();
    chk("all_good", 16'(320), 16'(cnt[1] + cnt[0] * 2));
    done("status");
  endtask : t_status
  task automatic t_regs;
    do_reset(1'b1);
    rd(8'h00, d);
    chk("ctrl_reset", 16'h0800, d);
    chk("pdo_active", 16'h0001, 16'(pdo_active_out));
    wr(8'h08, 16'h0000);
    rd(8'h08, d);
    chk("chan_counts", 16'h1111, d);
    rd(8'h40, d);
    chk("unmapped", 16'h0000, d);
    wr(8'h00, 16'h0033);
    repeat (5) @(posedge clock_in);
    chk("pdo_off", 16'h0000, 16'(pdo_active_out));
    chk("alias_saved", 16'h0033, 16'(alias_out));
    alias_switch_in <= 8'h25;
    repeat (5) @(posedge clock_in);
    chk("alias_switch", 16'h0025, 16'(alias_out));
    done("regs");
  endtask : t_regs
  task automatic t_leds;
    int run_on [4] = '{0, 160, 64, 320};
    int err_on [4] = '{0, 64, 128, 160};
    int p0_on [4] = '{0, 320, 0, 160};
    int p1_on [4] = '{0, 0, 320, 160};
    for (int i = 0; i < 4; i++)
    begin
      esm_state_in <= bfi_esm_t'(i);
      err_code_in <= bfi_err_t'(i);
      link_up_in <= 2'(i);
      activity_in <= 2'(i == 3 ? 3 : 0);
      meas();
      chk("run_led", 16'(run_on[i]), 16'(cnt[2]));
      chk("err_led", 16'(err_on[i]), 16'(cnt[3]));
      chk("port0_led", 16'(p0_on[i]), 16'(cnt[4]));
      chk("port1_led", 16'(p1_on[i]), 16'(cnt[5]));
    end
    done("leds");
  endtask : t_leds
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      errors++;
      wrap_up();
    end
  end
  initial
  begin
    for (int b = 0; b < 4; b++) t_probe(b);
    t_absent();
    t_status();
    t_regs();
    t_leds();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
